// [core/adc_ctl_pkg.sv]
// Shared constants and types of the converter sequence control block.
package adc_ctl_pkg;
  // Register byte offsets.
  localparam logic [11:0] OFF_INITIATE = 12'h028;
  localparam logic [11:0] OFF_AVG_CTL  = 12'h030;
  localparam logic [11:0] OFF_STATUS   = 12'h038;
  localparam logic [11:0] OFF_SEQ0_MUX = 12'h040;
  // Field layouts and values after reset.
  localparam logic [31:0] MUX_WR_MASK  = 32'h3333_3333;
  localparam logic [31:0] MUX_RESET    = 32'h0000_0000;
  localparam logic [2:0]  AVG_RESET    = 3'h0;
  localparam logic [3:0]  PEND_RESET   = 4'h0;
  localparam int          SLOT_PITCH   = 4;
  localparam int          ST_PEND_LSB  = 0;
  localparam int          ST_SEQ_LSB   = 4;
  localparam int          ST_STEP_LSB  = 8;
  localparam int          ST_BUSY_BIT  = 12;
  localparam logic [2:0]  STEP_MAX     = 3'h7;
  // Bus answers.
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_DECERR  = 2'b11;
  // Run sequencing states, Gray coded along the loop.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_WAIT = 2'b11,
    ST_STEP = 2'b10
  } run_state_type;
endpackage : adc_ctl_pkg

// [core/seq_priority_arbiter.sv]
// Picks the pending sequencer with the smallest priority value.
`timescale 1ns/10ps
`default_nettype none
module seq_priority_arbiter
  import adc_ctl_pkg::*;
#(
  parameter int NUM = 4
) (
  input  wire logic [NUM-1:0]   pending_i,
  input  wire logic [2*NUM-1:0] priority_i,
  output logic                  grant_valid_o,
  output logic [1:0]            grant_idx_o
);
  if (NUM != 4) begin : g_check
    $error("seq_priority_arbiter serves exactly four sequencers");
  end

  logic [1:0] best_prio;

  // Scan all sequencers; a smaller value wins, 0 is the most urgent.
  always_comb begin
    grant_valid_o = 1'b0;
    grant_idx_o   = 2'd0;
    best_prio     = 2'd3;
    for (int i = 0; i < NUM; i++) begin
      if (pending_i[i] && (!grant_valid_o || priority_i[2*i +: 2] < best_prio)) begin
        grant_valid_o = 1'b1;
        grant_idx_o   = 2'(i);
        best_prio     = priority_i[2*i +: 2];
      end
    end
  end
endmodule : seq_priority_arbiter
`default_nettype wire

// [core/sample_averager.sv]
// Sums 2^N conversions and emits their mean as one result.
`timescale 1ns/10ps
`default_nettype none
module sample_averager
  import adc_ctl_pkg::*;
#(
  parameter int DATA_W  = 10,
  parameter int MAX_EXP = 6
) (
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [2:0]        exp_i,
  input  wire logic              sample_valid_i,
  input  wire logic [DATA_W-1:0] sample_i,
  output logic                   group_last_o,
  output logic                   result_valid_o,
  output logic [DATA_W-1:0]      result_o
);
  localparam int ACC_W = DATA_W + MAX_EXP;
  if (MAX_EXP != 6 || DATA_W < 1) begin : g_check
    $error("sample_averager needs MAX_EXP of 6 and a positive width");
  end

  logic [MAX_EXP-1:0] cnt;
  logic [ACC_W-1:0]   acc;
  logic [ACC_W-1:0]   sum;
  logic [MAX_EXP-1:0] target;
  logic [MAX_EXP:0]   seen;

  // A setting of seven folds onto the largest group; its result is undefined anyway.
  assign target       = MAX_EXP'((32'd1 << exp_i) - 32'd1);
  assign group_last_o = (cnt == target);
  assign sum          = acc + {{MAX_EXP{1'b0}}, sample_i};

  // Accumulate the group, then divide by shifting and restart.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt            <= '0;
      acc            <= '0;
      result_valid_o <= 1'b0;
      result_o       <= '0;
    end else begin
      result_valid_o <= 1'b0;
      if (sample_valid_i) begin
        if (group_last_o) begin
          result_valid_o <= 1'b1;
          result_o       <= DATA_W'(sum >> exp_i);
          acc            <= '0;
          cnt            <= '0;
        end else begin
          acc <= sum;
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

  // Conversions taken since the last result, kept apart from cnt so the group size is checked.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seen <= '0;
    end else if (result_valid_o) begin
      seen <= {{MAX_EXP{1'b0}}, sample_valid_i};
    end else if (sample_valid_i) begin
      seen <= seen + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_pass_through;
    sample_valid_i && exp_i == 3'd0 |=> result_valid_o && result_o == $past(sample_i);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("single conversion not passed straight through");

  property p_full_group;
    exp_i == 3'd6 && result_valid_o |-> seen == {1'b1, {MAX_EXP{1'b0}}};
  endproperty
  a_full_group: assert property (p_full_group)
    else $error("group of 64 closed at the wrong count");

  property p_one_result;
    sample_valid_i && !group_last_o |=> !result_valid_o;
  endproperty
  a_one_result: assert property (p_one_result)
    else $error("result emitted before the group was complete");
endmodule : sample_averager
`default_nettype wire

// [core/adc_sequence_trigger_avg.sv]
// Software initiate, averaging control and sequencer-0 input selection behind AXI4-Lite.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - A one written to initiate bit n starts a sampling run on sequencer n.
// - An initiate aimed at a sequencer that is not enabled starts nothing.
// - One write may start any one or any combination of the four sequencers.
// - Sequencers started together run one after another by priority value.
// - The initiate register is write-only and its read value means nothing.
// - Each stored result is the mean of 2^N conversions, N being the 3-bit field.
// - With N at zero each conversion is stored as it is.
// - With N at six, 64 conversions make one result; six is the largest setting.
// - The input select register holds eight 2-bit slots at 4-bit pitch.
// - The averaging register resets to zero and its upper bits are read-only.
// - Sample step k of a sequencer-0 run uses input slot k.
// - A slot value selects the analog channel of the same number.
// - Each sequencer has a 2-bit priority, 0 highest and 3 lowest, all distinct.
module adc_sequence_trigger_avg
  import adc_ctl_pkg::*;
#(
  parameter int DATA_W = 10
) (
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [3:0]        seq_enable_i,
  input  wire logic [7:0]        seq_priority_i,
  input  wire logic [11:0]       last_step_i,
  input  wire logic [1:0]        ext_channel_i,
  input  wire logic              conv_done_i,
  input  wire logic [DATA_W-1:0] conv_data_i,
  output logic                   conv_req_o,
  output logic [1:0]             conv_channel_o,
  output logic                   fifo_wr_o,
  output logic [DATA_W-1:0]      fifo_data_o,
  output logic [1:0]             fifo_seq_o,
  output logic [2:0]             fifo_step_o,
  output logic                   run_busy_o
);
  if (DATA_W < 1 || DATA_W > 26) begin : g_check
    $error("DATA_W must lie between 1 and 26");
  end

  logic [11:0]         aw_addr;
  logic                aw_held;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                w_held;
  logic                do_write;
  logic                wr_init;
  logic [3:0]          init_set;
  logic [2:0]          averaging_exponent;
  logic [31:0]         seq0_input_select;
  logic [3:0]          pending;
  logic [3:0]          pend_clr;
  logic                grant_valid;
  logic [1:0]          grant_idx;
  run_state_type       state;
  logic [1:0]          cur_seq;
  logic [2:0]          step;
  logic [2:0]          last_step;
  logic [1:0]          next_channel;
  logic                sample_valid;
  logic                group_last;
  logic                avg_valid;
  logic [DATA_W-1:0]   avg_result;
  logic [31:0]         rd_value;
  logic                rd_hit;
  logic [11:0]         rd_addr;

  // Write address and data are caught independently, in either order.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      aw_addr       <= {s_axi_awaddr[11:2], 2'b00};
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel holding register.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_init  = do_write && aw_addr == OFF_INITIATE && w_strb[0];
  // Only enabled sequencers take the request; zeros pass nothing on.
  assign init_set = wr_init ? (w_data[3:0] & seq_enable_i) : 4'h0;

  // Write response, with a decode error for an address that maps nothing.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == OFF_INITIATE || aw_addr == OFF_AVG_CTL
                       || aw_addr == OFF_STATUS || aw_addr == OFF_SEQ0_MUX)
                      ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Averaging exponent; the bits above it stay zero.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      averaging_exponent <= AVG_RESET;
    end else if (do_write && aw_addr == OFF_AVG_CTL && w_strb[0]) begin
      averaging_exponent <= w_data[2:0];
    end
  end

  // Input slots of sequencer 0; reserved pairs between slots never store.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seq0_input_select <= MUX_RESET;
    end else if (do_write && aw_addr == OFF_SEQ0_MUX) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b]) begin
          seq0_input_select[8*b +: 8] <= w_data[8*b +: 8] & MUX_WR_MASK[8*b +: 8];
        end
      end
    end
  end

  // Pending runs; a new request wins over the grant that clears the same bit.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pending <= PEND_RESET;
    end else begin
      pending <= (pending & ~pend_clr) | init_set;
    end
  end

  assign pend_clr = (state == ST_IDLE && grant_valid) ? (4'h1 << grant_idx) : 4'h0;

  // Ordering of runs by programmed priority.
  seq_priority_arbiter #(
    .NUM (4)
  ) u_arbiter (
    .pending_i     (pending),
    .priority_i    (seq_priority_i),
    .grant_valid_o (grant_valid),
    .grant_idx_o   (grant_idx)
  );

  assign last_step    = last_step_i[3*cur_seq +: 3];
  // Sequencer 0 takes its channel from the slot of the current step.
  assign next_channel = (cur_seq == 2'd0)
                        ? seq0_input_select[SLOT_PITCH*step +: 2]
                        : ext_channel_i;
  assign sample_valid = state == ST_WAIT && conv_done_i && !conv_req_o;

  // Run sequencing: request, wait, repeat until the group closes, then step.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state   <= ST_IDLE;
      cur_seq <= 2'd0;
      step    <= 3'd0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (grant_valid) begin
            cur_seq <= grant_idx;
            step    <= 3'd0;
            state   <= ST_REQ;
          end
        end
        ST_REQ: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (sample_valid) begin
            state <= group_last ? ST_STEP : ST_REQ;
          end
        end
        ST_STEP: begin
          if (step == last_step || step == STEP_MAX) begin
            state <= ST_IDLE;
          end else begin
            step  <= step + 3'd1;
            state <= ST_REQ;
          end
        end
      endcase
    end
  end

  // One conversion request per pass through the request state.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_req_o     <= 1'b0;
      conv_channel_o <= 2'd0;
    end else begin
      conv_req_o <= (state == ST_REQ);
      if (state == ST_REQ) begin
        conv_channel_o <= next_channel;
      end
    end
  end

  // Busy flag for the outside world; the status register reads its own state != ST_IDLE test.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_busy_o <= 1'b0;
    end else begin
      run_busy_o <= (state != ST_IDLE) || grant_valid;
    end
  end

  // Hardware averaging of the conversions of one step.
  sample_averager #(
    .DATA_W  (DATA_W),
    .MAX_EXP (6)
  ) u_averager (
    .ref_clk_i      (ref_clk_i),
    .arst_n_i       (arst_n_i),
    .exp_i          (averaging_exponent),
    .sample_valid_i (sample_valid),
    .sample_i       (conv_data_i),
    .group_last_o   (group_last),
    .result_valid_o (avg_valid),
    .result_o       (avg_result)
  );

  // Each averaged result goes out as a single write toward the sequencer FIFO.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fifo_wr_o   <= 1'b0;
      fifo_data_o <= '0;
      fifo_seq_o  <= 2'd0;
      fifo_step_o <= 3'd0;
    end else begin
      fifo_wr_o <= avg_valid;
      if (avg_valid) begin
        fifo_data_o <= avg_result;
        fifo_seq_o  <= cur_seq;
        fifo_step_o <= step;
      end
    end
  end

  // Read decode; the initiate register reads as zero.
  always_comb begin
    rd_value = 32'h0;
    rd_hit   = 1'b1;
    unique case ({s_axi_araddr[11:2], 2'b00})
      OFF_INITIATE: rd_value = 32'h0;
      OFF_AVG_CTL:  rd_value = {29'h0, averaging_exponent};
      OFF_SEQ0_MUX: rd_value = seq0_input_select;
      OFF_STATUS: begin
        rd_value[ST_PEND_LSB +: 4] = pending;
        rd_value[ST_SEQ_LSB +: 2]  = cur_seq;
        rd_value[ST_STEP_LSB +: 3] = step;
        rd_value[ST_BUSY_BIT]      = state != ST_IDLE;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel, one read at a time.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
      rd_addr       <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_value;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
      rd_addr       <= {s_axi_araddr[11:2], 2'b00};
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  logic prio_ok;

  // The granted sequencer must beat every other pending one.
  always_comb begin
    prio_ok = 1'b1;
    for (int j = 0; j < 4; j++) begin
      if (pending[j] && 2'(j) != grant_idx
          && seq_priority_i[2*j +: 2] <= seq_priority_i[2*grant_idx +: 2]) begin
        prio_ok = 1'b0;
      end
    end
  end

  sequence s_init_write;
    wr_init && (w_data[3:0] & seq_enable_i) != 4'h0;
  endsequence

  property p_init_sets;
    s_init_write |=> (pending & $past(init_set)) == $past(init_set);
  endproperty
  a_init_sets: assert property (p_init_sets)
    else $error("initiate did not mark the sequencer pending");

  property p_init_disabled;
    wr_init |=> ((pending & ~$past(pending)) & ~$past(seq_enable_i)) == 4'h0;
  endproperty
  a_init_disabled: assert property (p_init_disabled)
    else $error("disabled sequencer became pending");

  property p_no_write_no_set;
    !wr_init |=> (pending & ~$past(pending)) == 4'h0;
  endproperty
  a_no_write_no_set: assert property (p_no_write_no_set)
    else $error("pending bit appeared without an initiate");

  property p_priority;
    state == ST_IDLE && grant_valid |-> prio_ok ##1 cur_seq == $past(grant_idx);
  endproperty
  a_priority: assert property (p_priority)
    else $error("run started out of priority order");

  property p_read_init;
    s_axi_rvalid && rd_addr == OFF_INITIATE |-> s_axi_rdata == 32'h0;
  endproperty
  a_read_init: assert property (p_read_init)
    else $error("initiate register read returned data");

  property p_avg_resv;
    s_axi_rvalid && rd_addr == OFF_AVG_CTL |-> s_axi_rdata[31:3] == 29'h0;
  endproperty
  a_avg_resv: assert property (p_avg_resv)
    else $error("averaging register reserved bits read nonzero");

  property p_mux_resv;
    (seq0_input_select & ~MUX_WR_MASK) == 32'h0;
  endproperty
  a_mux_resv: assert property (p_mux_resv)
    else $error("input select reserved bits were stored");

  property p_channel;
    conv_req_o && cur_seq == 2'd0
      |-> conv_channel_o == $past(seq0_input_select[SLOT_PITCH*step +: 2]);
  endproperty
  a_channel: assert property (p_channel)
    else $error("sequencer 0 used the wrong input slot");
endmodule : adc_sequence_trigger_avg
`default_nettype wire

// [verification/adc_sequence_trigger_avg_tb.sv]
// Self-checking bench of the converter sequence control block.
`timescale 1ns/10ps
`default_nettype none
module adc_sequence_trigger_avg_tb;
  import adc_ctl_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic [11:0] awaddr    = '0;
  logic [11:0] araddr    = '0;
  logic [11:0] last_step = '0;
  logic [31:0] wdata     = '0;
  logic        awvalid   = 1'b0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic        done      = 1'b0;
  logic [3:0]  enable    = '0;
  logic [3:0]  wstrb     = 4'hf;
  logic [7:0]  prio      = 8'he4;
  logic [1:0]  ext_ch    = '0;
  logic [9:0]  cdata     = '0;
  logic [15:0] lfsr      = 16'hc324;
  logic [31:0] mux;
  logic [16:0] sum       = '0;
  logic [6:0]  ord;
  int          cnt       = 0;
  int          cur_avg   = 0;
  int          num_errors = 0;
  int          n_compared = 0;
  logic [33:0] bus_q[$];
  logic [14:0] fifo_q[$];
  logic [6:0]  ord_q[$];
  wire logic        awready, wready, bvalid, arready, rvalid, conv_req, fifo_wr, busy;
  wire logic [1:0]  bresp, rresp, conv_ch, fifo_seq;
  wire logic [31:0] rdata;
  wire logic [9:0]  fifo_data;
  wire logic [2:0]  fifo_step;

  // Free-running system clock.
  always #12.5 ref_clk_i = ~ref_clk_i;

  adc_sequence_trigger_avg #(.DATA_W(10)) DUT (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .seq_enable_i(enable),
    .seq_priority_i(prio), .last_step_i(last_step), .ext_channel_i(ext_ch),
    .conv_done_i(done), .conv_data_i(cdata), .conv_req_o(conv_req),
    .conv_channel_o(conv_ch), .fifo_wr_o(fifo_wr), .fifo_data_o(fifo_data),
    .fifo_seq_o(fifo_seq), .fifo_step_o(fifo_step), .run_busy_o(busy)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp

  // One compare task per kind of result; each counts and reports through cmp.
  task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
    cmp(e, g);
  endtask : cmp_bus

  task automatic cmp_ch(input logic [33:0] e, input logic [33:0] g);
    cmp(e, g);
  endtask : cmp_ch

  task automatic cmp_fifo(input logic [33:0] e, input logic [33:0] g);
    cmp(e, g);
  endtask : cmp_fifo

  task automatic end_sim;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  // Write one word; address and data are released each at its own handshake.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge ref_clk_i);
    bus_q.push_back({er, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 100);
    bready <= 1'b0;
    if (t >= 100) num_errors++;
  endtask : wr

  // Read one word and note the expected data and response.
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge ref_clk_i);
    bus_q.push_back({er, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 100);
    rready <= 1'b0;
    if (t >= 100) num_errors++;
  endtask : rd

  // Wait until every noted run step has produced its result and the block is idle.
  task automatic settle;
    int t;
    t = 0;
    do begin
      @(posedge ref_clk_i);
      t++;
    end while ((ord_q.size() > 0 || fifo_q.size() > 0 || busy !== 1'b0) && t < 3000);
    if (t >= 3000) num_errors++;
  endtask : settle

  // Converter stand-in: answers each request a cycle later and notes the group mean.
  always @(posedge ref_clk_i) begin
    done <= 1'b0;
    if (conv_req === 1'b1) begin
      if (ord_q.size() == 0) num_errors++;
      else begin
        cmp_ch({31'h0, 1'b1, ord_q[0][1:0]}, {31'h0, busy, conv_ch});
        lfsr = lfsr_next(lfsr);
        done <= 1'b1;
        cdata <= lfsr[9:0];
        sum = sum + 17'(lfsr[9:0]);
        cnt++;
        if (cnt == (1 << cur_avg)) begin
          ord = ord_q.pop_front();
          fifo_q.push_back({ord[6:2], 10'(sum >> cur_avg)});
          sum = '0;
          cnt = 0;
        end
      end
    end
  end

  // Output watcher: takes the oldest note whenever an answer or a result appears.
  always @(posedge ref_clk_i) begin
    if (bvalid === 1'b1 && bready && bus_q.size() > 0) begin
      cmp_bus(bus_q.pop_front(), {bresp, 32'h0});
    end
    if (rvalid === 1'b1 && rready && bus_q.size() > 0) begin
      cmp_bus(bus_q.pop_front(), {rresp, rdata});
    end
    if (fifo_wr === 1'b1) begin
      if (fifo_q.size() == 0) begin
        num_errors++;
      end else begin
        cmp_fifo({19'h0, fifo_q.pop_front()}, {19'h0, fifo_seq, fifo_step, fifo_data});
      end
    end
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rd(OFF_AVG_CTL, 32'h0, RESP_OKAY);
    rd(OFF_SEQ0_MUX, MUX_RESET, RESP_OKAY);
    rd(OFF_INITIATE, 32'h0, RESP_OKAY);
    wr(12'h100, 32'h1, RESP_DECERR);
    rd(12'h100, 32'h0, RESP_DECERR);
    wr(OFF_SEQ0_MUX, 32'hffff_ffff, RESP_OKAY);
    rd(OFF_SEQ0_MUX, MUX_WR_MASK, RESP_OKAY);
    wr(OFF_AVG_CTL, 32'hffff_fffe, RESP_OKAY);
    rd(OFF_AVG_CTL, 32'h6, RESP_OKAY);
    // Eight-step run of sequencer 0 with random slots and no averaging.
    lfsr = lfsr_next(lfsr);
    mux = {lfsr, ~lfsr} & MUX_WR_MASK;
    wr(OFF_AVG_CTL, 32'h0, RESP_OKAY);
    cur_avg = 0;
    wr(OFF_SEQ0_MUX, mux, RESP_OKAY);
    enable <= 4'h1;
    last_step <= 12'h007;
    for (int k = 0; k < 8; k++) ord_q.push_back({2'd0, 3'(k), mux[4*k +: 2]});
    wr(OFF_INITIATE, 32'h1, RESP_OKAY);
    settle();
    // Status after the eight-step run: idle, nothing pending, last step seven.
    rd(OFF_STATUS, 32'h0000_0700, RESP_OKAY);
    // All four started at once, sequencer 2 disabled, priorities permuted.
    lfsr = lfsr_next(lfsr);
    ext_ch <= lfsr[1:0];
    enable <= 4'b1011;
    prio <= 8'h36;
    last_step <= 12'h008;
    wr(OFF_AVG_CTL, 32'h1, RESP_OKAY);
    cur_avg = 1;
    ord_q.push_back({2'd3, 3'd0, lfsr[1:0]});
    ord_q.push_back({2'd1, 3'd0, lfsr[1:0]});
    ord_q.push_back({2'd1, 3'd1, lfsr[1:0]});
    ord_q.push_back({2'd0, 3'd0, mux[1:0]});
    wr(OFF_INITIATE, 32'hf, RESP_OKAY);
    settle();
    // Averaging settings zero to six on a single-step run.
    enable <= 4'h1;
    last_step <= '0;
    for (int n = 0; n <= 6; n++) begin
      wr(OFF_AVG_CTL, 32'(n), RESP_OKAY);
      cur_avg = n;
      ord_q.push_back({5'h0, mux[1:0]});
      wr(OFF_INITIATE, 32'h1, RESP_OKAY);
      settle();
    end
    // Zeros in the initiate bits, or an unstrobed low byte, start nothing; drops stay dropped.
    enable <= 4'hf;
    wr(OFF_INITIATE, 32'hffff_fff0, RESP_OKAY);
    wstrb <= 4'he;
    wr(OFF_INITIATE, 32'h0000_000f, RESP_OKAY);
    wstrb <= 4'hf;
    repeat (30) @(posedge ref_clk_i);
    rd(OFF_AVG_CTL, 32'h6, RESP_OKAY);
    end_sim();
  end

  // Watchdog against a hung handshake or run.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    end_sim();
  end
endmodule : adc_sequence_trigger_avg_tb
`default_nettype wire
